// ### design/iopd_map.svh
// Offsets, field positions, codes and timing counts of the I/O block
`ifndef IOPD_MAP_SVH
`define IOPD_MAP_SVH

`define IOPD_CLK_MHZ         125
`define IOPD_A_CTRL          4'h0
`define IOPD_A_SAFE          4'h1
`define IOPD_A_OUTDLY        4'h2
`define IOPD_A_INDLY         4'h3
`define IOPD_A_WDOG          4'h4
`define IOPD_A_RESTORE       4'h5
`define IOPD_A_OUTPD         4'h6
`define IOPD_A_INPD          4'h7
`define IOPD_A_STATUS        4'h8
`define IOPD_A_EMCY_LO       4'h9
`define IOPD_A_EMCY_HI       4'hA
`define IOPD_A_LIVE          4'hB
`define IOPD_A_FW_DATA       4'hC
`define IOPD_A_FW_COUNT      4'hD
`define IOPD_CTRL_DC_BIT     0
`define IOPD_CTRL_BOOT_BIT   1
`define IOPD_CTRL_BUSOK_BIT  2
`define IOPD_EC_CLEAR        16'h0000
`define IOPD_EC_SUPPLY       16'h3000
`define IOPD_EC_TEMP         16'h4001
`define IOPD_ER_SUPPLY_BIT   2
`define IOPD_ER_TEMP_BIT     4
`define IOPD_DIAG_TEMP       8'h06
`define IOPD_FREERUN_DIV     16'h007D
`define IOPD_BLINK_DIV       24'h7A_1200
`define IOPD_WDOG_RESET      32'h00BE_BC20
`define IOPD_RESTORE_KEY     32'h0000_0001

`endif

// ### design/iopd_pkg.sv
// Types of the process data and diagnostic block
package iopd_pkg;
  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  err_reg;
    logic [39:0] diag;
  } iopd_emcy_t;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } iopd_bus_t;
  typedef enum logic [2:0] {
    IOPD_E_IDLE = 3'b001,
    IOPD_E_SEND = 3'b010,
    IOPD_E_WAIT = 3'b100
  } iopd_est_t;
endpackage

// ### design/iopd_sync2.sv
// Two-stage synchroniser for a vector of pins
`timescale 1ns/1ps
module iopd_sync2 #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule

// ### design/iopd_io.sv
// Process data, status word, emergency messages and sync, 8 in / 8 out
//
// Contract
// RULE1 - Output channel n follows bit n-1 of the output byte.
// RULE2 - Input channel n lands in bit n-1 of the input byte.
// RULE3 - Status bit 0 output short, bit 1 output overload, 31..6 zero.
// RULE4 - Status bits 2..5 report actuator and logic supply faults.
// RULE5 - Emergency message is code, error register, five diagnostic bytes.
// RULE6 - Supply faults send 3001..3005, register bit 2, diag 00 n 00 00.
// RULE7 - Overtemperature sends 4001, register bit 4, diag 00 06 00 00.
// RULE8 - Emergency messages are sent unprompted with no confirmation.
// RULE9 - A message is sent when a fault appears and when it leaves.
// RULE10 - When clearing send code 0000, drop the bit, keep diag bytes.
// RULE11 - Two update modes: event driven or clock driven by SYNC0.
// RULE12 - Event driven mode runs free and is the reset default.
// RULE13 - Clock driven mode updates outputs an output delay after SYNC0.
// RULE14 - Clock driven mode samples inputs an input delay after SYNC0.
// RULE15 - Clock driven mode takes effect only after a slave restart.
// RULE16 - Writing 1 to restore object requests defaults at next power up.
// RULE17 - After connection timeout outputs go to the configured safe state.
// RULE18 - After boot the ready indicator is steady or flashing green.
// RULE19 - Firmware image bytes from the file service are accepted.
// RULE20 - Multi-byte values are sent least significant byte first.
// RULE21 - Status bits follow their fault conditions level by level.
`timescale 1ns/1ps
`include "iopd_map.svh"
module iopd_io (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire iopd_pkg::iopd_bus_t i_bus,
  output logic [31:0]             o_rdata,
  input  wire logic               i_restart,
  input  wire logic               i_sync0,
  input  wire logic [7:0]         i_din,
  input  wire logic [5:0]         i_fault,
  input  wire logic [5:0]         i_supply,
  input  wire logic               i_overtemp,
  output logic [7:0]              o_dout,
  output logic                    o_ready_led,
  output logic                    o_emcy_valid,
  output logic [7:0]              o_emcy_byte,
  output logic                    o_restore_req,
  output logic                    o_fw_valid,
  output logic [7:0]              o_fw_byte
);
  import iopd_pkg::*;
  default clocking dclk @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  typedef struct packed {
    logic             dc_sel;
    logic             dc_act;
    logic             booted;
    logic             bus_ok;
    logic [7:0]       safe;
    logic [15:0]      out_dly;
    logic [15:0]      in_dly;
    logic [31:0]      wdog_lim;
    logic [31:0]      wdog_cnt;
    logic             timeout;
    logic             restore;
    logic [7:0]       out_pd;
    logic [7:0]       in_pd;
    logic [7:0]       dout;
    logic [15:0]      free_cnt;
    logic [15:0]      ocnt;
    logic             orun;
    logic [15:0]      icnt;
    logic             irun;
    logic             s0_q;
    logic [5:0]       sup_q;
    logic             tmp_q;
    logic [6:0]       pend;
    logic [7:0]       err_reg;
    iopd_emcy_t       msg;
    iopd_est_t        est;
    logic [2:0]       bidx;
    logic [23:0]      blink_cnt;
    logic             blink;
    logic [7:0]       emb;
    logic             emv;
    logic [7:0]       fwb;
    logic             fwv;
    logic [31:0]      fw_cnt;
    logic [31:0]      rdata;
  } iopd_state_t;

  iopd_state_t st;
  iopd_state_t next_st;
  logic [7:0]  din_s;
  logic        s0_s;
  logic [5:0]  sup_s;
  logic        tmp_s;
  logic [5:0]  flt_s;

  iopd_sync2 #(.W(22)) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({i_din, i_sync0, i_supply, i_overtemp, i_fault}),
    .o_q      ({din_s, s0_s, sup_s, tmp_s, flt_s})
  );

  // Build message for source k: 0..4 supply, 5 overtemp
  function automatic iopd_emcy_t mk_msg(input logic [2:0] k,
                                        input logic raise,
                                        input logic [7:0] er);
    iopd_emcy_t m;
    m.err_reg = er;
    m.diag    = {8'h00, 8'h00, 8'h00, 5'h00, k + 3'h1, 8'h00}; // [RULE6]
    if (!raise) begin
      m.code = `IOPD_EC_CLEAR;                                   // [RULE10]
    end else if (k == 3'd5) begin
      m.code = `IOPD_EC_TEMP;                                    // [RULE7]
    end else begin
      m.code = `IOPD_EC_SUPPLY + {13'h0000, k + 3'h1};           // [RULE6]
    end
    return m;
  endfunction

  // Byte i of the message as sent, code low byte first
  function automatic logic [7:0] msg_byte(input iopd_emcy_t m,
                                          input logic [2:0] i);
    logic [63:0] w;
    w = {m.diag, m.err_reg, m.code[15:8], m.code[7:0]};          // [RULE20]
    return w[8*i +: 8];
  endfunction

  logic [31:0] status;
  // Level status word, reserved bits zero [RULE3] [RULE4] [RULE21]
  assign status = {26'h000_0000, flt_s};

  always_comb begin
    logic [6:0] cur;
    logic [6:0] chg;
    logic [2:0] k;
    logic       hit;
    logic       upd_o;
    logic       upd_i;
    cur   = '0;
    chg   = '0;
    k     = '0;
    hit   = 1'b0;
    upd_o = 1'b0;
    upd_i = 1'b0;
    next_st = st;
    next_st.emv = 1'b0;
    next_st.fwv = 1'b0;
    next_st.s0_q = s0_s;
    next_st.sup_q = sup_s;
    next_st.tmp_q = tmp_s;

    // Register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        `IOPD_A_CTRL: begin
          next_st.dc_sel = i_bus.wdata[`IOPD_CTRL_DC_BIT];       // [RULE11]
          next_st.booted = i_bus.wdata[`IOPD_CTRL_BOOT_BIT];
          next_st.bus_ok = i_bus.wdata[`IOPD_CTRL_BUSOK_BIT];
        end
        `IOPD_A_SAFE:   next_st.safe     = i_bus.wdata[7:0];
        `IOPD_A_OUTDLY: next_st.out_dly  = i_bus.wdata[15:0];
        `IOPD_A_INDLY:  next_st.in_dly   = i_bus.wdata[15:0];
        `IOPD_A_WDOG:   next_st.wdog_lim = i_bus.wdata;
        `IOPD_A_RESTORE: begin
          if (i_bus.wdata == `IOPD_RESTORE_KEY) begin
            next_st.restore = 1'b1;                              // [RULE16]
          end
        end
        `IOPD_A_OUTPD: next_st.out_pd = i_bus.wdata[7:0];
        `IOPD_A_FW_DATA: begin
          next_st.fwb    = i_bus.wdata[7:0];                     // [RULE19]
          next_st.fwv    = 1'b1;
          next_st.fw_cnt = st.fw_cnt + 32'h0000_0001;
        end
        default: ;
      endcase
    end

    // Mode switch applies only at a restart [RULE15]
    if (i_restart) begin
      next_st.dc_act = st.dc_sel;
    end

    // Connection watchdog, refreshed by each output process data write
    if (i_bus.wr && i_bus.addr == `IOPD_A_OUTPD) begin
      next_st.wdog_cnt = '0;
      next_st.timeout  = !st.timeout && st.wdog_cnt >= st.wdog_lim;
    end else if (st.wdog_cnt >= st.wdog_lim) begin
      next_st.timeout = 1'b1;                                    // [RULE17]
    end else begin
      next_st.wdog_cnt = st.wdog_cnt + 32'h0000_0001;
    end

    // Update timing per mode
    if (!st.dc_act) begin
      next_st.free_cnt = st.free_cnt + 16'h0001;                 // [RULE12]
      if (st.free_cnt >= `IOPD_FREERUN_DIV - 16'h0001) begin
        next_st.free_cnt = '0;
        upd_o = 1'b1;
        upd_i = 1'b1;
      end
    end else begin
      if (s0_s && !st.s0_q) begin
        next_st.orun = 1'b1;
        next_st.ocnt = '0;
        next_st.irun = 1'b1;
        next_st.icnt = '0;
      end else begin
        if (st.orun) begin
          next_st.ocnt = st.ocnt + 16'h0001;
          if (st.ocnt >= st.out_dly) begin
            next_st.orun = 1'b0;
            upd_o = 1'b1;                                        // [RULE13]
          end
        end
        if (st.irun) begin
          next_st.icnt = st.icnt + 16'h0001;
          if (st.icnt >= st.in_dly) begin
            next_st.irun = 1'b0;
            upd_i = 1'b1;                                        // [RULE14]
          end
        end
      end
    end

    if (st.timeout) begin
      next_st.dout = st.safe;                                    // [RULE17]
    end else if (upd_o) begin
      next_st.dout = st.out_pd;                                  // [RULE1]
    end
    if (upd_i) begin
      next_st.in_pd = din_s;                                     // [RULE2]
    end

    // Fault edges queue a message each way [RULE9]
    cur = {1'b0, tmp_s, sup_s[4:0]};
    chg = {1'b0, cur[5:0] ^ {st.tmp_q, st.sup_q[4:0]}};
    next_st.pend = st.pend | chg;

    // Emergency sender, unconfirmed [RULE8]
    unique case (st.est)
      IOPD_E_IDLE: begin
        for (int i = 5; i >= 0; i--) begin
          if (st.pend[i]) begin
            k   = 3'(i);
            hit = 1'b1;
          end
        end
        if (hit) begin
          next_st.pend[k] = chg[k];
          if (k == 3'd5) begin
            next_st.err_reg[`IOPD_ER_TEMP_BIT] = cur[k];         // [RULE7]
          end else begin
            next_st.err_reg[`IOPD_ER_SUPPLY_BIT] =
              |(cur[4:0] & ~(5'h01 << k)) | cur[k];              // [RULE10]
          end
          next_st.msg  = mk_msg(k, cur[k], next_st.err_reg);
          next_st.bidx = '0;
          next_st.est  = IOPD_E_SEND;
        end
      end
      IOPD_E_SEND: begin
        next_st.emb  = msg_byte(st.msg, st.bidx);                // [RULE5]
        next_st.emv  = 1'b1;
        next_st.bidx = st.bidx + 3'h1;
        if (st.bidx == 3'h7) begin
          next_st.est = IOPD_E_WAIT;
        end
      end
      IOPD_E_WAIT: next_st.est = IOPD_E_IDLE;
      default:     next_st.est = IOPD_E_IDLE;
    endcase

    // Ready indicator flash divider [RULE18]
    if (st.blink_cnt >= `IOPD_BLINK_DIV) begin
      next_st.blink_cnt = '0;
      next_st.blink     = ~st.blink;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 24'h00_0001;
    end

    // Read data one cycle after strobe
    next_st.rdata = '0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `IOPD_A_CTRL:    next_st.rdata = {29'h0, st.bus_ok, st.booted,
                                          st.dc_sel};
        `IOPD_A_SAFE:    next_st.rdata = {24'h00_0000, st.safe};
        `IOPD_A_OUTDLY:  next_st.rdata = {16'h0000, st.out_dly};
        `IOPD_A_INDLY:   next_st.rdata = {16'h0000, st.in_dly};
        `IOPD_A_WDOG:    next_st.rdata = st.wdog_lim;
        `IOPD_A_RESTORE: next_st.rdata = {31'h0, st.restore};
        `IOPD_A_OUTPD:   next_st.rdata = {24'h00_0000, st.out_pd};
        `IOPD_A_INPD:    next_st.rdata = {24'h00_0000, st.in_pd};
        `IOPD_A_STATUS:  next_st.rdata = status;                 // [RULE3]
        `IOPD_A_EMCY_LO: next_st.rdata = {st.msg.diag[7:0],
                                          st.msg.err_reg,
                                          st.msg.code};          // [RULE20]
        `IOPD_A_EMCY_HI: next_st.rdata = st.msg.diag[39:8];
        `IOPD_A_LIVE:    next_st.rdata = {28'h000_0000, st.timeout,
                                          st.dc_act, st.est == IOPD_E_IDLE,
                                          st.blink};
        `IOPD_A_FW_COUNT: next_st.rdata = st.fw_cnt;
        default:         next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st          <= '0;
      st.est      <= IOPD_E_IDLE;
      st.wdog_lim <= `IOPD_WDOG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata       = st.rdata;
  assign o_dout        = st.dout;
  assign o_emcy_valid  = st.emv;
  assign o_emcy_byte   = st.emb;
  assign o_restore_req = st.restore;
  assign o_fw_valid    = st.fwv;
  assign o_fw_byte     = st.fwb;
  // Off before boot; after boot steady when bus is up, flashing otherwise [RULE18]
  assign o_ready_led   = st.booted & (st.bus_ok | st.blink);

  a_out_map: assert property ( // [RULE1]
    (!st.timeout && !st.dc_act && st.free_cnt == `IOPD_FREERUN_DIV - 16'h1)
    |=> o_dout == $past(st.out_pd))
    else $error("outputs not loaded from output byte");
  a_in_map: assert property ( // [RULE2]
    (!st.dc_act && st.free_cnt == `IOPD_FREERUN_DIV - 16'h1)
    |=> st.in_pd == $past(din_s))
    else $error("inputs not sampled");
  a_stat_word: assert property ( // [RULE3]
    i_bus.rd && i_bus.addr == `IOPD_A_STATUS
    |=> o_rdata[31:6] == 26'h0 && o_rdata[5:0] == $past(flt_s))
    else $error("status word wrong");
  a_msg_len: assert property ( // [RULE5]
    $rose(o_emcy_valid) |-> o_emcy_valid [*8] ##1 !o_emcy_valid)
    else $error("message not eight bytes");
  a_clr_code: assert property ( // [RULE10]
    st.est == IOPD_E_SEND && st.bidx == 3'h0 && st.msg.code == 16'h0
    |-> st.msg.diag[15:8] != 8'h00)
    else $error("clear message lost diag");
  a_temp_code: assert property ( // [RULE7]
    st.est == IOPD_E_SEND && st.msg.code == `IOPD_EC_TEMP
    |-> st.msg.err_reg[`IOPD_ER_TEMP_BIT]
        && st.msg.diag[15:8] == `IOPD_DIAG_TEMP)
    else $error("overtemperature message wrong");
  a_safe_out: assert property ( // [RULE17]
    st.timeout |=> o_dout == $past(st.safe))
    else $error("safe state not applied");
  a_mode_hold: assert property ( // [RULE15]
    !i_restart |=> st.dc_act == $past(st.dc_act))
    else $error("mode changed without restart");
endmodule

// ### dv/iopd_master_model.sv
// Fieldbus master model: takes emergency and firmware bytes, makes SYNC0
`timescale 1ns/1ps
module iopd_master_model (
  input  wire logic       i_clk,
  input  wire logic       i_emcy_valid,
  input  wire logic [7:0] i_emcy_byte,
  input  wire logic       i_fw_valid,
  input  wire logic [7:0] i_fw_byte,
  output logic            o_sync0
);
  logic [63:0] msg = 64'h0000_0000_0000_0000;
  logic [63:0] acc = 64'h0000_0000_0000_0000;
  logic [7:0]  fw = 8'h00;
  int          n_msg = 0;
  int          n_byte = 0;
  int          n_bad = 0;

  initial o_sync0 = 1'b0;

  // Bytes are only taken; the model never answers a message
  always @(posedge i_clk) begin
    if (i_emcy_valid) begin
      acc[8*n_byte +: 8] <= i_emcy_byte;
      n_byte <= n_byte + 1;
    end else if (n_byte != 0) begin
      if (n_byte != 8) n_bad <= n_bad + 1;
      msg <= acc;
      n_msg <= n_msg + 1;
      n_byte <= 0;
    end
    if (i_fw_valid) fw <= i_fw_byte;
  end

  task automatic fire_sync0();
    @(posedge i_clk);
    o_sync0 <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_sync0 <= 1'b0;
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench of the process data and diagnostic block
`timescale 1ns/1ps
`include "iopd_map.svh"
module testbench;
  import iopd_pkg::*;
  localparam logic [31:0] M = 32'hFFFF_FFFF;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  iopd_bus_t   i_bus = '0;
  logic        i_restart = 1'b0;
  logic [7:0]  i_din = 8'h00;
  logic [5:0]  i_fault = 6'h00;
  logic [5:0]  i_supply = 6'h00;
  logic        i_overtemp = 1'b0;
  logic        sync0;
  logic [31:0] o_rdata;
  logic [7:0]  o_dout;
  logic        o_ready_led;
  logic        o_emcy_valid;
  logic [7:0]  o_emcy_byte;
  logic        o_restore_req;
  logic        o_fw_valid;
  logic [7:0]  o_fw_byte;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          seen;

  iopd_io uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_restart(i_restart), .i_sync0(sync0),
    .i_din(i_din), .i_fault(i_fault), .i_supply(i_supply),
    .i_overtemp(i_overtemp), .o_dout(o_dout), .o_ready_led(o_ready_led),
    .o_emcy_valid(o_emcy_valid), .o_emcy_byte(o_emcy_byte),
    .o_restore_req(o_restore_req), .o_fw_valid(o_fw_valid),
    .o_fw_byte(o_fw_byte));

  iopd_master_model master (.i_clk(i_clk), .i_emcy_valid(o_emcy_valid),
    .i_emcy_byte(o_emcy_byte), .i_fw_valid(o_fw_valid),
    .i_fw_byte(o_fw_byte), .o_sync0(sync0));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                    input logic [31:0] m);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), {32'h0, exp}, {32'h0, o_rdata & m});
  endtask

  function automatic logic [63:0] em(input logic [15:0] c,
                                     input logic [7:0] e,
                                     input logic [7:0] n);
    return {24'h00_0000, n, 8'h00, e, c};
  endfunction

  task automatic emcy(input logic [63:0] exp);
    seen = master.n_msg;
    for (int k = 0; k < 60 && master.n_msg == seen; k++) @(posedge i_clk);
    #1 chk("emergency", exp, master.msg);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`IOPD_A_CTRL, 32'h0000_0000, M);
    rd(`IOPD_A_WDOG, 32'h00BE_BC20, M);
    rd(4'hE, 32'h0000_0000, M);
    rd(`IOPD_A_STATUS, 32'h0000_0000, M);
    rd(`IOPD_A_LIVE, 32'h0000_0000, 32'h0000_0004);
    chk("ready", 1'b0, o_ready_led);
    i_din <= 8'hA5;
    wr(`IOPD_A_OUTPD, 32'h0000_0081);
    repeat (300) @(posedge i_clk);
    chk("dout", 8'h81, o_dout);
    rd(`IOPD_A_INPD, 32'h0000_00A5, M);
    for (int i = 0; i < 6; i++) begin
      i_fault <= 6'h01 << i;
      repeat (4) @(posedge i_clk);
      rd(`IOPD_A_STATUS, 32'h0000_0001 << i, M);
    end
    i_fault <= 6'h00;
    repeat (4) @(posedge i_clk);
    rd(`IOPD_A_STATUS, 32'h0000_0000, M);
    for (int n = 1; n <= 5; n++) begin
      i_supply <= 6'h01 << (n - 1);
      emcy(em(16'h3000 + 16'(n), 8'h04, 8'(n)));
      i_supply <= 6'h00;
      emcy(em(16'h0000, 8'h00, 8'(n)));
    end
    i_overtemp <= 1'b1;
    emcy(em(16'h4001, 8'h10, 8'h06));
    rd(`IOPD_A_EMCY_LO, 32'h0010_4001, M);
    rd(`IOPD_A_EMCY_HI, 32'h0000_0006, M);
    i_overtemp <= 1'b0;
    emcy(em(16'h0000, 8'h00, 8'h06));
    wr(`IOPD_A_CTRL, 32'h0000_0006);
    repeat (2) @(posedge i_clk);
    chk("ready", 1'b1, o_ready_led);
    chk("restore", 1'b0, o_restore_req);
    wr(`IOPD_A_RESTORE, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    chk("restore", 1'b1, o_restore_req);
    wr(`IOPD_A_FW_DATA, 32'h0000_00C3);
    repeat (2) @(posedge i_clk);
    chk("fw byte", 8'hC3, master.fw);
    rd(`IOPD_A_FW_COUNT, 32'h0000_0001, M);
    wr(`IOPD_A_OUTDLY, 32'h0000_0014);
    wr(`IOPD_A_INDLY, 32'h0000_000A);
    wr(`IOPD_A_CTRL, 32'h0000_0007);
    rd(`IOPD_A_LIVE, 32'h0000_0000, 32'h0000_0004);
    @(posedge i_clk);
    i_restart <= 1'b1;
    @(posedge i_clk);
    i_restart <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(`IOPD_A_LIVE, 32'h0000_0004, 32'h0000_0004);
    i_din <= 8'hC3;
    wr(`IOPD_A_OUTPD, 32'h0000_005A);
    repeat (300) @(posedge i_clk);
    chk("dout", 8'h81, o_dout);
    rd(`IOPD_A_INPD, 32'h0000_00A5, M);
    master.fire_sync0();
    repeat (5) @(posedge i_clk);
    chk("dout", 8'h81, o_dout);
    repeat (40) @(posedge i_clk);
    chk("dout", 8'h5A, o_dout);
    rd(`IOPD_A_INPD, 32'h0000_00C3, M);
    wr(`IOPD_A_SAFE, 32'h0000_003C);
    wr(`IOPD_A_WDOG, 32'h0000_0064);
    repeat (300) @(posedge i_clk);
    chk("dout", 8'h3C, o_dout);
    rd(`IOPD_A_LIVE, 32'h0000_0008, 32'h0000_0008);
    chk("frames", 64'h0, master.n_bad);
    end_of_test();
  end
endmodule
